// *** hdl/bbpl_defines.svh ***
`ifndef BBPL_DEFINES_SVH
`define BBPL_DEFINES_SVH

// Keypad value that starts and completes the forgotten-password recovery (decimal 9999).
`define BBPL_PW_RECOVERY 16'h270F
// Consecutive wrong entries that raise the lock fault.
`define BBPL_WRONG_LIMIT 2'h3
// Fault history codes.
`define BBPL_CODE_BB 8'h33
`define BBPL_CODE_LOCK 8'h34
`define BBPL_CODE_NONE 8'h00
// Recovery window in seconds and the clock rate in hertz.
`define BBPL_RCV_WINDOW_S 10
`define BBPL_MCLK_HZ 50000000
// Width of the recovery timer.
`define BBPL_TMR_W 32

`endif

// *** hdl/bbpl_pkg.sv ***
package bbpl_pkg;

	// Recovery sequence states, one-hot.
	typedef enum logic [2:0] {
		BBPL_RCV_IDLE = 3'h1,
		BBPL_RCV_ENTER = 3'h2,
		BBPL_RCV_SECOND = 3'h4
	} bbpl_rcv_e;

	// One keypad event: a numeric entry to the password parameter or the enter key.
	typedef struct packed {
		logic vld;
		logic enter;
		logic [15:0] val;
	} bbpl_key_s;

	// One fault history record.
	typedef struct packed {
		logic vld;
		logic [7:0] code;
	} bbpl_frec_s;

endpackage

// *** hdl/bbpl_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser; the output follows once stages two and three agree.
module bbpl_sync (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// Shift chain; the first stage feeds only the second.
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else if (ce) begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Accept a new level only when the two later stages agree.
	always_ff @(posedge mclk) begin
		if (rst) begin
			dout <= 1'b0;
		end else if (ce && (s2_ff == s3_ff)) begin
			dout <= s3_ff;
		end
	end
endmodule

// *** hdl/bbpl_top.sv ***
`timescale 1ns/1ns
`include "bbpl_defines.svh"
module bbpl_top #(
	parameter int unsigned RCV_CYCLES = `BBPL_RCV_WINDOW_S * `BBPL_MCLK_HZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mfi_pin,
	input wire logic mfi_is_bb,
	input wire bbpl_pkg::bbpl_key_s key,
	input wire logic [15:0] pw_stored,
	output logic out_en,
	output logic bb_disp,
	output logic lock_fault,
	output bbpl_pkg::bbpl_frec_s frec,
	output logic dflt_restore,
	output logic unlock_ok,
	output logic [1:0] wrong_cnt
);
	import bbpl_pkg::*;

	localparam logic [`BBPL_TMR_W-1:0] TMR_LAST = `BBPL_TMR_W'(RCV_CYCLES - 1);

	logic mfi_sync;
	logic bb_req;
	logic pw_try;
	logic pw_ok;
	logic pw_bad;
	logic key_is_rcv;
	logic rcv_timeout;
	logic rcv_done;
	bbpl_rcv_e rcv_ff;
	bbpl_rcv_e nxt_rcv;
	logic [`BBPL_TMR_W-1:0] tmr_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Base block
	////////////////////////////////////////////////////////////////////////////////

	// The terminal is a pin, so it is synchronised before use.
	bbpl_sync u_mfi_sync (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.din(mfi_pin),
		.dout(mfi_sync)
	);

	assign bb_req = mfi_sync & mfi_is_bb;

	// Output gating and indication track the input level with no latching.
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_en <= 1'b1;
			bb_disp <= 1'b0;
		end else if (ce) begin
			out_en <= ~bb_req;
			bb_disp <= bb_req;
		end
	end

	bb_cut_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && mfi_sync && mfi_is_bb) |=> (!out_en && bb_disp))
		else $error("Base block did not cut the output.");

	bb_release_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && !(mfi_sync && mfi_is_bb)) |=> (out_en && !bb_disp))
		else $error("Base block indication did not clear by itself.");

	// A record stands while the enable is low, so only a fresh record must coincide with a new lock.
	bb_nolog_a: assert property (@(posedge mclk) disable iff (rst)
		frec.vld |-> (frec.code == `BBPL_CODE_LOCK && lock_fault && ($rose(lock_fault) || !$past(ce))))
		else $error("A record was logged for something other than a new lock.");

	////////////////////////////////////////////////////////////////////////////////
	// Password check
	////////////////////////////////////////////////////////////////////////////////

	// Normal entries are only judged while the lock is clear.
	assign pw_try = key.vld & ~lock_fault;
	assign pw_ok = pw_try & (key.val == pw_stored);
	assign pw_bad = pw_try & (key.val != pw_stored);

	// Consecutive wrong entries; a good entry or a recovery clears the count.
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrong_cnt <= 2'h0;
		end else if (ce) begin
			if (rcv_done || pw_ok) begin
				wrong_cnt <= 2'h0;
			end else if (pw_bad && wrong_cnt != `BBPL_WRONG_LIMIT) begin
				wrong_cnt <= wrong_cnt + 2'h1;
			end
		end
	end

	// The lock sets on the third miss and stays until power-on or recovery.
	always_ff @(posedge mclk) begin
		if (rst) begin
			lock_fault <= 1'b0;
		end else if (ce) begin
			if (rcv_done) begin
				lock_fault <= 1'b0;
			end else if (pw_bad && wrong_cnt == `BBPL_WRONG_LIMIT - 2'h1) begin
				lock_fault <= 1'b1;
			end
		end
	end

	// Fault history entry and success pulses.
	always_ff @(posedge mclk) begin
		if (rst) begin
			frec <= '0;
			unlock_ok <= 1'b0;
			dflt_restore <= 1'b0;
		end else if (ce) begin
			frec.vld <= pw_bad && wrong_cnt == `BBPL_WRONG_LIMIT - 2'h1;
			frec.code <= (pw_bad && wrong_cnt == `BBPL_WRONG_LIMIT - 2'h1) ? `BBPL_CODE_LOCK : `BBPL_CODE_NONE;
			unlock_ok <= pw_ok | rcv_done;
			dflt_restore <= rcv_done;
		end
	end

	lock_third_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && key.vld && !lock_fault && key.val != pw_stored && wrong_cnt == 2'h2)
		|=> (lock_fault && frec.vld && frec.code == `BBPL_CODE_LOCK))
		else $error("Third wrong entry did not raise and log the lock.");

	lock_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(lock_fault && !(ce && rcv_done)) |=> lock_fault)
		else $error("Lock dropped without recovery or power-on.");

	lock_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && lock_fault && key.vld && key.val == pw_stored && rcv_ff != BBPL_RCV_SECOND)
		|=> (!unlock_ok && lock_fault))
		else $error("Correct password accepted while locked.");

	cnt_clear_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && !lock_fault && key.vld && key.val == pw_stored) |=> (wrong_cnt == 2'h0 && unlock_ok))
		else $error("Correct entry did not clear the wrong counter.");

	////////////////////////////////////////////////////////////////////////////////
	// Recovery sequence
	////////////////////////////////////////////////////////////////////////////////

	assign key_is_rcv = key.vld & (key.val == `BBPL_PW_RECOVERY);
	assign rcv_timeout = (rcv_ff != BBPL_RCV_IDLE) && (tmr_ff == TMR_LAST);
	assign rcv_done = (rcv_ff == BBPL_RCV_SECOND) && key_is_rcv && !rcv_timeout;

	// Next state; any stray entry or a timeout abandons the attempt.
	always_comb begin
		nxt_rcv = rcv_ff;
		case (rcv_ff)
			BBPL_RCV_IDLE: begin
				if (lock_fault && key_is_rcv) begin
					nxt_rcv = BBPL_RCV_ENTER;
				end
			end
			BBPL_RCV_ENTER: begin
				if (rcv_timeout || key.vld) begin
					nxt_rcv = BBPL_RCV_IDLE;
				end else if (key.enter) begin
					nxt_rcv = BBPL_RCV_SECOND;
				end
			end
			BBPL_RCV_SECOND: begin
				if (rcv_timeout || key.vld) begin
					nxt_rcv = BBPL_RCV_IDLE;
				end
			end
			default: begin
				nxt_rcv = BBPL_RCV_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rcv_ff <= BBPL_RCV_IDLE;
		end else if (ce) begin
			rcv_ff <= nxt_rcv;
		end
	end

	// Window timer runs from the first recovery entry.
	always_ff @(posedge mclk) begin
		if (rst) begin
			tmr_ff <= '0;
		end else if (ce) begin
			if (rcv_ff == BBPL_RCV_IDLE) begin
				tmr_ff <= '0;
			end else if (!rcv_timeout) begin
				tmr_ff <= tmr_ff + `BBPL_TMR_W'(1);
			end
		end
	end

	rcv_expire_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && rcv_ff != BBPL_RCV_IDLE && tmr_ff == TMR_LAST) |=> (rcv_ff == BBPL_RCV_IDLE && !dflt_restore))
		else $error("Recovery attempt outlived its window.");

	rcv_seq_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && rcv_ff == BBPL_RCV_ENTER && !key.vld && key.enter && tmr_ff != TMR_LAST)
		|=> (rcv_ff == BBPL_RCV_SECOND))
		else $error("Enter key did not advance the recovery sequence.");

	rcv_default_a: assert property (@(posedge mclk) disable iff (rst)
		(ce && rcv_ff == BBPL_RCV_SECOND && key.vld && key.val == `BBPL_PW_RECOVERY && tmr_ff != TMR_LAST)
		|=> (dflt_restore && !lock_fault && wrong_cnt == 2'h0))
		else $error("Recovery did not unlock and restore defaults.");

endmodule

// *** test/bbpl_keypad_model.sv ***
`timescale 1ns/1ns
// Keypad operator model: turns bench requests into one-cycle key events.
module bbpl_keypad_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] op,
	input wire logic [15:0] val,
	output bbpl_pkg::bbpl_key_s key
);
	import bbpl_pkg::*;
	logic [15:0] last_ff;
	// Remember the bus value so that idle cycles never repeat the previous cycle's data.
	always_ff @(posedge mclk) begin
		if (rst) begin
			last_ff <= 16'h0000;
		end else begin
			last_ff <= key.val;
		end
	end
	// Entry value, enter key, and a toggling value bus between events.
	always_comb begin
		key.vld = (op == 2'h1);
		key.enter = (op == 2'h2);
		key.val = key.vld ? val : ~last_ff;
	end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
	import bbpl_pkg::*;
	localparam int unsigned RCV = 50;
	logic mclk, rst, ce, mfi_pin, mfi_is_bb, out_en, bb_disp, lock_fault, dflt_restore, unlock_ok, p, s;
	logic [1:0] op, wrong_cnt;
	logic [15:0] val, pw_stored;
	bbpl_key_s key;
	bbpl_frec_s frec;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	bbpl_keypad_model u_kp (.mclk(mclk), .rst(rst), .op(op), .val(val), .key(key));
	bbpl_top #(.RCV_CYCLES(RCV)) u_dut (.mclk(mclk), .rst(rst), .ce(ce), .mfi_pin(mfi_pin),
		.mfi_is_bb(mfi_is_bb), .key(key), .pw_stored(pw_stored), .out_en(out_en), .bb_disp(bb_disp),
		.lock_fault(lock_fault), .frec(frec), .dflt_restore(dflt_restore), .unlock_ok(unlock_ok),
		.wrong_cnt(wrong_cnt));
	////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Cut a hung run short.
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			wrap_up();
		end
	end
	// Compare one value and report a mismatch.
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One key event; returns once the design has taken it.
	task automatic step(input logic [1:0] o, input logic [15:0] v);
		@(posedge mclk);
		op <= o;
		val <= v;
		@(posedge mclk);
		op <= 2'h0;
		#1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Three wrong entries in a row must lock and log exactly once.
	task automatic lock_up();
		for (int i = 0; i < 3; i++) begin
			step(2'h1, ~pw_stored);
			chk("wrong_cnt", wrong_cnt, 16'(i + 1));
			chk("lock_fault", lock_fault, i == 2);
			chk("frec", frec, {i == 2, i == 2 ? 8'h34 : 8'h00});
		end
	endtask
	function automatic logic exp_bb(input logic pin, input logic sel);
		return pin & sel;
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		void'($urandom(32'hae3f));
		rst = 1'b1;
		ce = 1'b1;
		mfi_pin = 1'b0;
		mfi_is_bb = 1'b1;
		op = 2'h0;
		val = 16'h0000;
		pw_stored = 16'($urandom_range(9998));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		idle(1);
		chk("out_en", out_en, 1'b1);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		step(2'h1, pw_stored);
		chk("unlock_ok", unlock_ok, 1'b1);
		step(2'h1, pw_stored ^ 16'h0001);
		step(2'h1, pw_stored + 16'h0002);
		chk("wrong_cnt", wrong_cnt, 2'h2);
		step(2'h1, pw_stored);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		$display("test password count done");
		lock_up();
		step(2'h1, pw_stored);
		chk("unlock_ok", unlock_ok, 1'b0);
		chk("lock_fault", lock_fault, 1'b1);
		step(2'h1, 16'h270F);
		idle(RCV + 5);
		step(2'h2, 16'h0000);
		step(2'h1, 16'h270F);
		chk("unlock_ok", unlock_ok, 1'b0);
		step(2'h2, 16'h0000);
		step(2'h1, 16'h270F);
		chk("dflt_restore", dflt_restore, 1'b1);
		chk("unlock_ok", unlock_ok, 1'b1);
		chk("lock_fault", lock_fault, 1'b0);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		idle(1);
		chk("dflt_restore", dflt_restore, 1'b0);
		$display("test recovery done");
		lock_up();
		@(posedge mclk);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		idle(1);
		chk("lock_fault", lock_fault, 1'b0);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		chk("frec", frec, 9'h000);
		$display("test power cycle done");
		// With the enable low a wrong entry must leave every count untouched.
		@(posedge mclk);
		ce <= 1'b0;
		step(2'h1, ~pw_stored);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		@(posedge mclk);
		ce <= 1'b1;
		step(2'h1, ~pw_stored);
		chk("wrong_cnt", wrong_cnt, 2'h1);
		step(2'h1, pw_stored);
		chk("wrong_cnt", wrong_cnt, 2'h0);
		$display("test clock enable done");
		for (int i = 0; i < 12; i++) begin
			p = (i < 4) ? i[0] : 1'($urandom);
			s = (i < 4) ? i[1] : 1'($urandom);
			@(posedge mclk);
			mfi_pin <= p;
			mfi_is_bb <= s;
			idle(7);
			chk("out_en", out_en, !exp_bb(p, s));
			chk("bb_disp", bb_disp, exp_bb(p, s));
			chk("frec", frec, 9'h000);
		end
		$display("test base block done");
		wrap_up();
	end
endmodule
